// [rtl/ccw3_pkg.sv]
// Constants for the core capability word three register.
// Assumes a single core clock and an active-low power-on reset.
`default_nettype none
package ccw3_pkg;
    // Register select of this word within the coprocessor space
    localparam logic [4:0]  CCW3_REG_NUM        = 5'h10;
    localparam logic [2:0]  CCW3_REG_SEL        = 3'h3;
    // Field positions
    localparam int          BIT_NEXT_WORD       = 31;
    localparam int          PRIO_WIDTH_LSB      = 21;
    localparam int          ISA_REV_LSB         = 18;
    localparam int          BIT_MCU_EXT         = 17;
    localparam int          BIT_EXC_ISA         = 16;
    localparam int          ISA_AVAIL_LSB       = 14;
    localparam int          BIT_ULR             = 13;
    localparam int          BIT_RXI             = 12;
    localparam int          BIT_DSP2            = 11;
    localparam int          BIT_DSP             = 10;
    localparam int          BIT_FLOW_TRACE      = 8;
    localparam int          BIT_EXT_VEC         = 6;
    localparam int          BIT_VEC_IRQ         = 5;
    localparam int          BIT_SMALL_PAGE      = 4;
    localparam int          BIT_COMMON_DEVICE_MAP_PRESENT            = 3;
    localparam int          BIT_TRACE_LOGIC     = 0;
    localparam int          BOOT_ISA_CFG_BIT    = 6;
    // Fixed field values
    localparam logic [1:0]  PRIO_WIDTH_VAL      = 2'h1;
    localparam logic [2:0]  ISA_REV_VAL         = 3'h0;
    localparam logic [1:0]  ISA_BOOT_COMPRESSED = 2'h3;
    localparam logic [1:0]  ISA_BOOT_BASE       = 2'h2;
    // Constant part of the word; ISA fields are ORed in separately
    localparam logic [31:0] CCW3_FIXED          = 32'h8022_3D68;
endpackage
`default_nettype wire

// [rtl/ccw3_boot_latch.sv]
// Captures the boot ISA strap once after power-on reset release.
// Assumes strap input is stable during and after reset, from the clock's domain.
`default_nettype none
module ccw3_boot_latch (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Strap in
    input  wire logic strapIn,
    // Captured value
    output var  logic boot_isa_config_bit,
    output var  logic loadPulse
);
    logic doneR_r;
    logic doneR_nxt;
    logic boot_isa_config_bit_nxt;
    always_comb begin
        doneR_nxt   = 1'b1;
        boot_isa_config_bit_nxt = doneR_r ? boot_isa_config_bit : strapIn;
    end
    // Strap taken on first edge after release, not under reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            doneR_r   <= 1'b0;
            boot_isa_config_bit   <= 1'b0;
            loadPulse <= 1'b0;
        end else begin
            doneR_r   <= doneR_nxt;
            boot_isa_config_bit   <= boot_isa_config_bit_nxt;
            loadPulse <= !doneR_r;
        end
    end
endmodule
`default_nettype wire

// [rtl/ccw3_exc_isa.sv]
// Holds the writable exception-entry ISA select bit.
// Assumes the boot latch load pulse arrives once after reset.
`default_nettype none
module ccw3_exc_isa (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Load and write
    input  wire logic loadPulse,
    input  wire logic boot_isa_config_bit,
    input  wire logic wrEn,
    input  wire logic wrBit,
    // State
    output var  logic excIsa
);
    logic excIsa_nxt;
    always_comb begin
        excIsa_nxt = excIsa;
        if (loadPulse) begin
            excIsa_nxt = boot_isa_config_bit;
        end else if (wrEn) begin
            excIsa_nxt = wrBit;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            excIsa <= 1'b0;
        end else begin
            excIsa <= excIsa_nxt;
        end
    end
endmodule
`default_nettype wire

// [rtl/ccw3_core_config.sv]
// Core capability word three: read-mostly configuration register.
// Assumes coprocessor accesses are single-cycle strobes on the core clock.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// - Top bit reads one, writes ignored
// - Unimplemented bits always read zero
// - Priority width field reads 01
// - Compressed ISA revision reads 000
// - Bit 17 reads one, MCU extension
// - Bit 16 writable exception-entry ISA select
// - Bits 15-14 read 11 or 10
// - Boot strap loads ISA fields after reset release
// - Bit 13 reads one, user-local register
// - Bit 12 reads one, inhibit bits
// - Bit 11 reads one, DSP rev two
// - Bit 10 reads one, DSP present
// - Bit 8 reads one, flow trace
// - Bit 6 reads one, external vectoring
// - Bit 5 reads one, vectored interrupts
// - Bit 4 reads zero, 4 KB pages
// - Bit 3 reads one, device map
// - Bit 0 reads zero, no trace
module ccw3_core_config (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Boot configuration strap (bit 6 of device config word zero)
    input  wire logic        bootIsaConfigBit,
    // Coprocessor register access
    input  wire logic [4:0]  regNum,
    input  wire logic [2:0]  regSel,
    input  wire logic        rdEn,
    input  wire logic        wrEn,
    input  wire logic [31:0] wrData,
    output var  logic [31:0] rdData,
    output var  logic        rdValid,
    // Live state toward the core
    output var  logic        excEntryIsa,
    output var  logic        resetIsaCompressed
);
    ////////////////////////////////////////////////////////////////////////////
    logic        boot_isa_config_bit;
    logic        loadPulse;
    logic        excIsa;
    logic        hit;
    logic [31:0] wordVal;
    logic [31:0] rdData_nxt;
    logic        rdValid_nxt;
    logic        excOut_nxt;
    logic        rstIsaOut_nxt;
    logic [1:0]  isaAvail;

    ccw3_boot_latch u_boot (
        .clock     (clock),
        .rst_n     (rst_n),
        .strapIn   (bootIsaConfigBit),
        .boot_isa_config_bit   (boot_isa_config_bit),
        .loadPulse (loadPulse)
    );

    assign hit = (regNum == ccw3_pkg::CCW3_REG_NUM) && (regSel == ccw3_pkg::CCW3_REG_SEL);

    // Only bit 16 is taken from a write; bits 15-14 follow the boot strap, all else is hardwired
    ccw3_exc_isa u_exc (
        .clock     (clock),
        .rst_n     (rst_n),
        .loadPulse (loadPulse),
        .boot_isa_config_bit   (boot_isa_config_bit),
        .wrEn      (wrEn && hit),
        .wrBit     (wrData[ccw3_pkg::BIT_EXC_ISA]),
        .excIsa    (excIsa)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        isaAvail = boot_isa_config_bit ? ccw3_pkg::ISA_BOOT_COMPRESSED : ccw3_pkg::ISA_BOOT_BASE;
        wordVal  = ccw3_pkg::CCW3_FIXED;
        wordVal[ccw3_pkg::BIT_EXC_ISA] = excIsa;
        wordVal[ccw3_pkg::ISA_AVAIL_LSB +: 2] = isaAvail;
        rdValid_nxt   = rdEn && hit;
        rdData_nxt    = (rdEn && hit) ? wordVal : 32'h0000_0000;
        excOut_nxt    = excIsa;
        rstIsaOut_nxt = boot_isa_config_bit;
    end
    // Fixed image also

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdData             <= 32'h0000_0000;
            rdValid            <= 1'b0;
            excEntryIsa        <= 1'b0;
            resetIsaCompressed <= 1'b0;
        end else begin
            rdData             <= rdData_nxt;
            rdValid            <= rdValid_nxt;
            excEntryIsa        <= excOut_nxt;
            resetIsaCompressed <= rstIsaOut_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the read image
    top_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[31]) else $error("top bit not one");

    zero_bits_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> (rdData[30:23] == 8'h00 && !rdData[9] && !rdData[7] && rdData[2:1] == 2'h0))
        else $error("unimplemented bits nonzero");

    prio_width_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[22:21] == 2'h1) else $error("priority width wrong");

    isa_rev_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[20:18] == 3'h0) else $error("isa revision wrong");

    flags_one_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> (rdData[17] && rdData[13] && rdData[12] && rdData[11] && rdData[10]
                     && rdData[8] && rdData[6] && rdData[5] && rdData[3]))
        else $error("capability flag cleared");

    flags_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> (!rdData[4] && !rdData[0])) else $error("page or trace flag set");

    mcu_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_MCU_EXT]) else $error("extension flag cleared");

    ulr_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_ULR]) else $error("user local flag cleared");

    inhibit_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_RXI]) else $error("inhibit flag cleared");

    dsp_two_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_DSP2]) else $error("dsp rev two flag cleared");

    dsp_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_DSP]) else $error("dsp flag cleared");

    flow_trace_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_FLOW_TRACE]) else $error("flow trace flag cleared");

    ext_vec_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_EXT_VEC]) else $error("external vector flag cleared");

    vec_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_VEC_IRQ]) else $error("vectored flag cleared");

    small_page_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> !rdData[ccw3_pkg::BIT_SMALL_PAGE]) else $error("small page flag set");

    dev_map_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_COMMON_DEVICE_MAP_PRESENT]) else $error("device map flag cleared");

    trace_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> !rdData[ccw3_pkg::BIT_TRACE_LOGIC]) else $error("trace logic flag set");

    isa_field_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[15:14] == {1'b1, $past(boot_isa_config_bit)}) else $error("isa field wrong");

    exc_image_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[ccw3_pkg::BIT_EXC_ISA] == $past(excIsa)) else $error("select bit image wrong");

    // One check per hardwired bit; bits 16 to 14 (select bit and ISA field) are covered above
    for (genvar b = 0; b < 32; b++) begin : g_fixed_bit
        if (b < ccw3_pkg::ISA_AVAIL_LSB || b > ccw3_pkg::BIT_EXC_ISA) begin : g_chk
            fixed_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
                rdValid |-> rdData[b] == ccw3_pkg::CCW3_FIXED[b]) else $error("hardwired bit moved");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the access handshake
    read_lat_a: assert property (@(posedge clock) disable iff (!rst_n)
        (rdEn && hit) |=> rdValid) else $error("read answer missing");

    read_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
        !(rdEn && hit) |=> !rdValid) else $error("read answer without request");

    // Idle bus shows zero so a stale word cannot be mistaken for an answer
    read_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
        !rdValid |-> rdData == 32'h0000_0000) else $error("read data not idle");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the writable select bit
    exc_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        (wrEn && hit && !loadPulse) |-> ##2 excEntryIsa == $past(wrData[16], 2))
        else $error("exception isa write lost");

    exc_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!loadPulse && !(wrEn && hit)) |=> excIsa == $past(excIsa))
        else $error("select bit moved without write");

    exc_pipe_a: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> excEntryIsa == $past(excIsa)) else $error("select output lags wrongly");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the boot load
    boot_load_a: assert property (@(posedge clock) disable iff (!rst_n)
        loadPulse |=> excIsa == $past(boot_isa_config_bit)) else $error("boot load missed");

    // Strap must not be re-sampled once taken; a late strap change is ignored
    boot_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        u_boot.doneR_r |=> boot_isa_config_bit == $past(boot_isa_config_bit)) else $error("boot strap re-sampled");

    rst_isa_a: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> resetIsaCompressed == $past(boot_isa_config_bit)) else $error("reset isa output wrong");

    // Cycles since reset release, saturating; only feeds the checks below
    logic [1:0] relCnt_r;
    logic [1:0] relCnt_nxt;

    always_comb begin
        relCnt_nxt = (relCnt_r == 2'h3) ? relCnt_r : relCnt_r + 2'h1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            relCnt_r <= 2'h0;
        end else begin
            relCnt_r <= relCnt_nxt;
        end
    end

    load_once_a: assert property (@(posedge clock) disable iff (!rst_n)
        loadPulse |-> relCnt_r == 2'h1) else $error("boot load outside first cycle");

    load_seen_a: assert property (@(posedge clock) disable iff (!rst_n)
        (relCnt_r == 2'h1) |-> loadPulse) else $error("boot load pulse missing");

    load_single_a: assert property (@(posedge clock) disable iff (!rst_n)
        loadPulse |=> !loadPulse) else $error("boot load pulse too long");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the ISA availability field
    isa_avail_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> (rdData[15:14] == ccw3_pkg::ISA_BOOT_COMPRESSED
                     || rdData[15:14] == ccw3_pkg::ISA_BOOT_BASE))
        else $error("isa field illegal code");

    isa_match_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdValid |-> rdData[14] == resetIsaCompressed) else $error("isa field and output differ");

    // Both copies come from the same latch, so after the load they agree until bit 16 is written
    isa_agree_a: assert property (@(posedge clock) disable iff (!rst_n)
        (relCnt_r == 2'h3 && !$past(wrEn && hit) && !$past(wrEn && hit, 2) && u_boot.doneR_r
         && excEntryIsa == resetIsaCompressed) |=> (excEntryIsa == resetIsaCompressed || $past(wrEn && hit)))
        else $error("select and reset isa split without write");
endmodule
`default_nettype wire

// [dv/test_core_config_capability_reg.sv]
// Self-checking bench for the core capability word three register.
// Assumes the design's package and modules are compiled first; bench drives ports directly.
`default_nettype none
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin nMismatch++; \
    $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module test_core_config_capability_reg;
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    logic        clock            = 1'b0;
    logic        rst_n            = 1'b0;
    logic        bootIsaConfigBit = 1'b1;
    logic [4:0]  regNum           = 5'h00;
    logic [2:0]  regSel           = 3'h0;
    logic        rdEn             = 1'b0;
    logic        wrEn             = 1'b0;
    logic [31:0] wrData           = 32'h0000_0000;
    logic [31:0] rdData;
    logic        rdValid;
    logic        excEntryIsa;
    logic        resetIsaCompressed;
    int          nMismatch        = 0;
    int          totalChecks      = 0;
    always #4 clock = ~clock;
    ccw3_core_config i_dut (
        .clock              (clock),
        .rst_n              (rst_n),
        .bootIsaConfigBit   (bootIsaConfigBit),
        .regNum             (regNum),
        .regSel             (regSel),
        .rdEn               (rdEn),
        .wrEn               (wrEn),
        .wrData             (wrData),
        .rdData             (rdData),
        .rdValid            (rdValid),
        .excEntryIsa        (excEntryIsa),
        .resetIsaCompressed (resetIsaCompressed)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // Expected word: fixed flags, then exception select and the ISA field (top bit always one)
    function automatic logic [31:0] expWord(input logic strap, input logic exc);
        expWord = 32'h8022_3D68 | {15'h0000, exc, 1'b1, strap, 14'h0000};
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Strap is held across reset; first access only after the boot load has landed
    task automatic doReset(input logic strap);
        @(posedge clock);
        rst_n <= 1'b0;
        bootIsaConfigBit <= strap;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic access(input logic [4:0] num, input logic [2:0] sel, input logic rd, input logic wr,
                          input logic [31:0] data);
        @(posedge clock);
        regNum <= num;
        regSel <= sel;
        rdEn <= rd;
        wrEn <= wr;
        wrData <= data;
        @(posedge clock);
        rdEn <= 1'b0;
        wrEn <= 1'b0;
        #1;
    endtask
    // Answer is a one-cycle pulse, so it is looked at once and then must be gone
    task automatic readChk(input logic [31:0] expVal);
        access(ccw3_pkg::CCW3_REG_NUM, ccw3_pkg::CCW3_REG_SEL, 1'b1, 1'b0, 32'h0000_0000);
        `CHK(rdValid, 1'b1)
        `CHK(rdData, expVal)
        @(posedge clock);
        #1;
        `CHK(rdValid, 1'b0)
        `CHK(rdData, 32'h0000_0000)
    endtask
    task automatic writeChk(input logic [4:0] num, input logic [2:0] sel, input logic [31:0] data,
                            input logic expExc);
        access(num, sel, 1'b0, 1'b1, data);
        @(posedge clock);
        #1;
        `CHK(excEntryIsa, expExc)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        doReset(1'b1);
        `CHK(resetIsaCompressed, 1'b1)
        `CHK(excEntryIsa, 1'b1)
        readChk(expWord(1'b1, 1'b1));
        readChk(expWord(1'b1, 1'b1));
        // All ones except the select bit: only bit 16 may move
        writeChk(ccw3_pkg::CCW3_REG_NUM, ccw3_pkg::CCW3_REG_SEL, 32'hFFFE_FFFF, 1'b0);
        readChk(expWord(1'b1, 1'b0));
        writeChk(ccw3_pkg::CCW3_REG_NUM, ccw3_pkg::CCW3_REG_SEL, 32'h0001_0000, 1'b1);
        readChk(expWord(1'b1, 1'b1));
        // Writes with a foreign select or number and reads with a foreign select are ignored
        writeChk(ccw3_pkg::CCW3_REG_NUM, 3'h2, 32'h0000_0000, 1'b1);
        writeChk(5'h0F, ccw3_pkg::CCW3_REG_SEL, 32'h0000_0000, 1'b1);
        access(ccw3_pkg::CCW3_REG_NUM, 3'h2, 1'b1, 1'b0, 32'h0000_0000);
        `CHK(rdValid, 1'b0)
        `CHK(rdData, 32'h0000_0000)
        // Read and write in one cycle returns the old value, the next read the new one
        access(ccw3_pkg::CCW3_REG_NUM, ccw3_pkg::CCW3_REG_SEL, 1'b1, 1'b1, 32'h0000_0000);
        `CHK(rdData, expWord(1'b1, 1'b1))
        readChk(expWord(1'b1, 1'b0));
        // Second power-on with the base-set strap
        doReset(1'b0);
        `CHK(resetIsaCompressed, 1'b0)
        `CHK(excEntryIsa, 1'b0)
        readChk(expWord(1'b0, 1'b0));
        writeChk(ccw3_pkg::CCW3_REG_NUM, ccw3_pkg::CCW3_REG_SEL, 32'h0001_0000, 1'b1);
        readChk(expWord(1'b0, 1'b1));
        test_done();
    end
    // Whole sequence needs under a hundred cycles; this leaves ample margin
    initial begin
        repeat (2000) @(posedge clock);
        nMismatch++;
        test_done();
    end
endmodule
`default_nettype wire
